// ---- logic/vfd_scan.sv ----
// vfd_scan: fluorescent display scanner with APB register access.
// assumes an APB master on clock_in; driver outputs feed external
// high-voltage buffers pulled down to the tube supply.
`timescale 1ns/100ps
module vfd_scan #(
    parameter int NUM_PINS = 37,
    parameter int NUM_SLOTS = 16
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [15:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [36:0] hv_pin_in,
    output logic [36:0] driver_outputs_out,
    output logic [1:0] rise_time_mode_out,
    output logic [3:0] time_slot_out
);

    if (NUM_PINS != vfd_pkg::VFD_NUM_PINS) begin : g_chk_pins
        $error("vfd_scan supports 37 driver outputs only");
    end
    if (NUM_SLOTS != vfd_pkg::VFD_NUM_SLOTS) begin : g_chk_slots
        $error("vfd_scan supports sixteen time slots only");
    end

    ////////////////////////////////////////////////////////////////////
    // bus decode
    logic [11:0] idx;
    logic addr_ok;
    logic setup_ph;
    logic wr_take;
    logic in_buf;
    logic [6:0] buf_addr;
    logic [11:0] buf_off;

    assign idx = paddr_in[13:2];
    assign addr_ok = (paddr_in[1:0] == 2'h0) && (paddr_in[15:14] == 2'h0);
    assign setup_ph = psel_in && !penable_in;
    assign wr_take = psel_in && penable_in && pready_out && pwrite_in;
    assign in_buf = (idx >= vfd_pkg::VFD_IDX_BUF_FIRST) &&
                    (idx <= vfd_pkg::VFD_IDX_BUF_LAST);
    assign buf_off = idx - vfd_pkg::VFD_IDX_BUF_FIRST;
    assign buf_addr = buf_off[6:0];

    logic hit;

    always_comb begin
        hit = 1'b0;
        if (addr_ok) begin
            case (idx)
                vfd_pkg::VFD_IDX_CTRL_FIRST,
                vfd_pkg::VFD_IDX_CTRL_SECOND,
                vfd_pkg::VFD_IDX_CTRL_THIRD,
                vfd_pkg::VFD_IDX_STATUS,
                vfd_pkg::VFD_IDX_LATCH_LO,
                vfd_pkg::VFD_IDX_LATCH_HI,
                vfd_pkg::VFD_IDX_PIN_LO,
                vfd_pkg::VFD_IDX_PIN_HI: hit = 1'b1;
                default: hit = in_buf;
            endcase
        end
    end

    logic wr_ok;
    assign wr_ok = wr_take && addr_ok && pstrb_in[0];

    ////////////////////////////////////////////////////////////////////
    // control registers
    logic blank_q;
    logic [1:0] slot_sel_q;
    logic [4:0] pin_sel_q;
    logic [3:0] phase_q;
    logic [3:0] bright_q;
    logic [1:0] rise_q;
    logic [36:0] latch_q;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            blank_q <= vfd_pkg::VFD_BLANK_RST;
            slot_sel_q <= vfd_pkg::VFD_SLOT_SEL_RST;
            pin_sel_q <= vfd_pkg::VFD_PIN_SEL_RST;
        end else if (wr_ok && idx == vfd_pkg::VFD_IDX_CTRL_FIRST) begin
            blank_q <= pwdata_in[vfd_pkg::VFD_BLANK_BIT];
            slot_sel_q <= pwdata_in[vfd_pkg::VFD_SLOT_SEL_LSB +: 2];
            pin_sel_q <= pwdata_in[vfd_pkg::VFD_PIN_SEL_LSB +: 5];
        end
    end

    // brightness is taken at any time, including while scanning
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q <= vfd_pkg::VFD_PHASE_RST;
            bright_q <= vfd_pkg::VFD_BRIGHT_RST;
        end else if (wr_ok && idx == vfd_pkg::VFD_IDX_CTRL_SECOND) begin
            phase_q <= pwdata_in[vfd_pkg::VFD_PHASE_LSB +: 4];
            bright_q <= pwdata_in[vfd_pkg::VFD_BRIGHT_LSB +: 4];
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rise_q <= vfd_pkg::VFD_RISE_RST;
        end else if (wr_ok && idx == vfd_pkg::VFD_IDX_CTRL_THIRD) begin
            rise_q[0] <= pwdata_in[vfd_pkg::VFD_RISE_69_BIT];
            rise_q[1] <= pwdata_in[vfd_pkg::VFD_RISE_D_BIT];
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            latch_q <= vfd_pkg::VFD_LATCH_RST;
        end else if (wr_ok && idx == vfd_pkg::VFD_IDX_LATCH_LO) begin
            latch_q[31:0] <= pwdata_in;
        end else if (wr_ok && idx == vfd_pkg::VFD_IDX_LATCH_HI) begin
            latch_q[36:32] <= pwdata_in[4:0];
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rise_time_mode_out <= vfd_pkg::VFD_RISE_RST;
        end else begin
            rise_time_mode_out <= rise_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // display buffer
    logic [7:0] buf_rd;
    logic [39:0] row;
    logic [3:0] slot_q;

    vfd_buffer #(
        .NUM_SLOTS(vfd_pkg::VFD_NUM_SLOTS),
        .NUM_GROUPS(vfd_pkg::VFD_NUM_GROUPS)
    ) u_buffer (
        .clock_in(clock_in),
        .wr_en_in(wr_ok && in_buf),
        .wr_addr_in(buf_addr),
        .wr_data_in(pwdata_in[7:0]),
        .rd_addr_in(buf_addr),
        .rd_data_out(buf_rd),
        .row_slot_in(slot_q),
        .row_out(row)
    );

    ////////////////////////////////////////////////////////////////////
    // scanner
    vfd_pkg::vfd_state_t state_q;
    logic [11:0] cnt_q;
    logic [11:0] slot_last;
    logic slot_end;
    logic done_q;

    assign slot_last = 12'((1 << (vfd_pkg::VFD_SLOT_EXP_BASE +
                                  int'(slot_sel_q))) - 1);
    assign slot_end = (state_q == vfd_pkg::VFD_ST_SCAN) &&
                      (cnt_q == slot_last);

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= vfd_pkg::VFD_ST_IDLE;
        end else begin
            case (state_q)
                vfd_pkg::VFD_ST_IDLE: begin
                    if (!blank_q) begin
                        state_q <= vfd_pkg::VFD_ST_SCAN;
                    end
                end
                vfd_pkg::VFD_ST_SCAN: begin
                    if (slot_end && blank_q) begin
                        state_q <= vfd_pkg::VFD_ST_IDLE;
                    end
                end
                default: state_q <= vfd_pkg::VFD_ST_IDLE;
            endcase
        end
    end

    // each slot lasts slot_last + 1 cycles
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= 12'h000;
        end else if (state_q != vfd_pkg::VFD_ST_SCAN || slot_end) begin
            cnt_q <= 12'h000;
        end else begin
            cnt_q <= cnt_q + 12'h001;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            slot_q <= 4'h0;
        end else if (state_q == vfd_pkg::VFD_ST_IDLE) begin
            slot_q <= 4'h0;
        end else if (slot_end && !blank_q) begin
            if (slot_q >= phase_q) begin
                slot_q <= 4'h0;
            end else begin
                slot_q <= slot_q + 4'h1;
            end
        end
    end

    // done sets as the slot in progress ends with blank set; cleared when scanning restarts
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            done_q <= vfd_pkg::VFD_DONE_RST;
        end else if (slot_end && blank_q) begin
            done_q <= 1'b1;
        end else if (state_q == vfd_pkg::VFD_ST_IDLE && !blank_q) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            time_slot_out <= 4'h0;
        end else begin
            time_slot_out <= slot_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // dimmer: drive while the top four counter bits do not pass brightness
    logic [11:0] cnt_top;
    logic lit;

    assign cnt_top = cnt_q >> (vfd_pkg::VFD_BRIGHT_SHIFT + int'(slot_sel_q));
    assign lit = (state_q == vfd_pkg::VFD_ST_SCAN) &&
                 (cnt_top[3:0] <= bright_q);

    ////////////////////////////////////////////////////////////////////
    // driver outputs; a set latch holds the pin high as plain output
    for (genvar i = 0; i < vfd_pkg::VFD_NUM_PINS; i++) begin : g_pin
        logic disp_en;
        if (i >= vfd_pkg::VFD_PORT_D_FIRST) begin : g_port_d
            assign disp_en = pin_sel_q[i - vfd_pkg::VFD_PORT_D_FIRST];
        end else begin : g_port_69
            assign disp_en = 1'b1;
        end

        always_ff @(posedge clock_in or posedge rst_in) begin
            if (rst_in) begin
                driver_outputs_out[i] <= 1'b0;
            end else begin
                driver_outputs_out[i] <= latch_q[i] |
                                         (disp_en & lit & row[i]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, registered in the setup phase
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0;
        case (idx)
            vfd_pkg::VFD_IDX_CTRL_FIRST: begin
                rd_mux[vfd_pkg::VFD_BLANK_BIT] = blank_q;
                rd_mux[vfd_pkg::VFD_SLOT_SEL_LSB +: 2] = slot_sel_q;
                rd_mux[vfd_pkg::VFD_PIN_SEL_LSB +: 5] = pin_sel_q;
            end
            vfd_pkg::VFD_IDX_CTRL_SECOND: begin
                rd_mux[vfd_pkg::VFD_PHASE_LSB +: 4] = phase_q;
                rd_mux[vfd_pkg::VFD_BRIGHT_LSB +: 4] = bright_q;
            end
            vfd_pkg::VFD_IDX_CTRL_THIRD: begin
                rd_mux[vfd_pkg::VFD_RISE_69_BIT] = rise_q[0];
                rd_mux[vfd_pkg::VFD_RISE_D_BIT] = rise_q[1];
            end
            vfd_pkg::VFD_IDX_STATUS: begin
                rd_mux[vfd_pkg::VFD_DONE_BIT] = done_q;
                rd_mux[vfd_pkg::VFD_RUN_BIT] =
                    (state_q == vfd_pkg::VFD_ST_SCAN);
                rd_mux[vfd_pkg::VFD_SLOT_LSB +: 4] = slot_q;
            end
            vfd_pkg::VFD_IDX_LATCH_LO: rd_mux = latch_q[31:0];
            vfd_pkg::VFD_IDX_LATCH_HI: rd_mux[4:0] = latch_q[36:32];
            vfd_pkg::VFD_IDX_PIN_LO: rd_mux = hv_pin_in[31:0];
            vfd_pkg::VFD_IDX_PIN_HI: rd_mux[4:0] = hv_pin_in[36:32];
            default: begin
                if (in_buf) begin
                    rd_mux[7:0] = buf_rd;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else begin
            pready_out <= setup_ph;
            pslverr_out <= setup_ph && !hit;
            if (setup_ph && hit && !pwrite_in) begin
                prdata_out <= rd_mux;
            end else begin
                prdata_out <= 32'h0;
            end
        end
    end

endmodule

// ---- logic/vfd_pkg.sv ----
// vfd_pkg: constants shared by the fluorescent display scanner files.
// assumes APB with 32-bit data; register index times four is the byte
// address, the low two address bits are zero.
package vfd_pkg;

    // register indices; byte address is four times the index
    localparam logic [11:0] VFD_IDX_CTRL_FIRST = 12'h02a;
    localparam logic [11:0] VFD_IDX_CTRL_SECOND = 12'h02b;
    localparam logic [11:0] VFD_IDX_CTRL_THIRD = 12'h02c;
    localparam logic [11:0] VFD_IDX_STATUS = 12'h02d;
    localparam logic [11:0] VFD_IDX_LATCH_LO = 12'h030;
    localparam logic [11:0] VFD_IDX_LATCH_HI = 12'h031;
    localparam logic [11:0] VFD_IDX_PIN_LO = 12'h032;
    localparam logic [11:0] VFD_IDX_PIN_HI = 12'h033;
    localparam logic [11:0] VFD_IDX_BUF_FIRST = 12'hf80;
    localparam logic [11:0] VFD_IDX_BUF_LAST = 12'hfcf;

    // display_ctrl_first fields
    localparam int VFD_BLANK_BIT = 0;
    localparam int VFD_SLOT_SEL_LSB = 1;
    localparam int VFD_PIN_SEL_LSB = 3;
    localparam logic VFD_BLANK_RST = 1'b1;
    localparam logic [1:0] VFD_SLOT_SEL_RST = 2'h0;
    localparam logic [4:0] VFD_PIN_SEL_RST = 5'h00;

    // display_ctrl_second fields
    localparam int VFD_PHASE_LSB = 0;
    localparam int VFD_BRIGHT_LSB = 4;
    localparam logic [3:0] VFD_PHASE_RST = 4'hf;
    localparam logic [3:0] VFD_BRIGHT_RST = 4'hf;

    // display_ctrl_third fields
    localparam int VFD_RISE_69_BIT = 0;
    localparam int VFD_RISE_D_BIT = 1;
    localparam logic [1:0] VFD_RISE_RST = 2'h0;

    // display_status_reg fields
    localparam int VFD_DONE_BIT = 0;
    localparam int VFD_RUN_BIT = 1;
    localparam int VFD_SLOT_LSB = 4;
    localparam logic VFD_DONE_RST = 1'b1;

    localparam logic [36:0] VFD_LATCH_RST = 37'h0;

    // slot length is two to the power (base + select) clock cycles
    localparam int VFD_SLOT_EXP_BASE = 9;
    localparam int VFD_SLOT_CNT_W = 12;
    // brightness compares the top four bits of the slot counter
    localparam int VFD_BRIGHT_SHIFT = VFD_SLOT_EXP_BASE - 4;

    localparam int VFD_NUM_PINS = 37;
    localparam int VFD_NUM_SLOTS = 16;
    localparam int VFD_NUM_GROUPS = 5;
    localparam int VFD_PORT_D_FIRST = 32;

    typedef enum logic {
        VFD_ST_IDLE,
        VFD_ST_SCAN
    } vfd_state_t;

endpackage

// ---- logic/vfd_buffer.sv ----
// vfd_buffer: display buffer memory, five byte groups of sixteen slots.
// assumes one write port from the register bus; two asynchronous read
// ports, one for the bus and one that returns a whole slot row.
`timescale 1ns/100ps
module vfd_buffer #(
    parameter int NUM_SLOTS = 16,
    parameter int NUM_GROUPS = 5
) (
    input wire logic clock_in,
    input wire logic wr_en_in,
    input wire logic [6:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [6:0] rd_addr_in,
    output logic [7:0] rd_data_out,
    input wire logic [3:0] row_slot_in,
    output logic [8*NUM_GROUPS-1:0] row_out
);

    localparam int DEPTH = NUM_SLOTS * NUM_GROUPS;

    if (NUM_SLOTS != 16) begin : g_chk_slots
        $error("vfd_buffer supports sixteen slots only");
    end

    ////////////////////////////////////////////////////////////////////
    // storage has no reset; contents are undefined until written
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clock_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    assign rd_data_out = mem[rd_addr_in];

    ////////////////////////////////////////////////////////////////////
    // slot n takes byte n of each group, group g feeds pins 8g..8g+7
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_row
        assign row_out[8*g +: 8] = mem[g*NUM_SLOTS + row_slot_in];
    end

endmodule

// ---- test/vfd_scan_checker.sv ----
// vfd_scan_checker: bus and scan timing assertions for vfd_scan.
// assumes it is bound onto vfd_scan and sees only that module's ports.
`timescale 1ns/100ps
module vfd_scan_checker #(
    parameter int NUM_PINS = 37,
    parameter int NUM_SLOTS = 16
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [15:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [36:0] hv_pin_in,
    input wire logic [36:0] driver_outputs_out,
    input wire logic [1:0] rise_time_mode_out,
    input wire logic [3:0] time_slot_out
);
    localparam logic [15:0] BUF_LO = {2'b00, vfd_pkg::VFD_IDX_BUF_FIRST, 2'b00};
    localparam logic [15:0] BUF_HI = {2'b00, vfd_pkg::VFD_IDX_BUF_LAST, 2'b00};
    localparam logic [15:0] THIRD = {2'b00, vfd_pkg::VFD_IDX_CTRL_THIRD, 2'b00};
    logic [3:0] last_q;
    logic [11:0] hold_q;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            last_q <= 4'h0;
        end else begin
            last_q <= time_slot_out;
        end
    end
    // cycles since the slot output last moved, saturating
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            hold_q <= 12'h000;
        end else if (time_slot_out != last_q) begin
            hold_q <= 12'h000;
        end else if (hold_q != 12'hfff) begin
            hold_q <= hold_q + 12'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence setup_s;
        psel_in && !penable_in;
    endsequence
    sequence wr_third_s;
        psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0]
            && paddr_in == THIRD;
    endsequence
    chk_ready_follows: assert property (
        setup_s |=> pready_out) else $error("ready missing after setup");
    chk_ready_single: assert property (
        pready_out |=> !pready_out) else $error("ready longer than a cycle");
    chk_err_misalign: assert property (
        setup_s ##0 (paddr_in[1:0] != 2'h0) |=> pslverr_out)
        else $error("misaligned access not refused");
    chk_buf_mapped: assert property (
        setup_s ##0 (paddr_in[1:0] == 2'h0 && paddr_in >= BUF_LO
            && paddr_in <= BUF_HI) |=> pready_out && !pslverr_out)
        else $error("buffer access refused");
    chk_err_ready: assert property (
        pslverr_out |-> pready_out) else $error("error without ready");
    chk_rdata_quiet: assert property (
        !pready_out |-> prdata_out == 32'h0) else $error("read data leaks");
    // the register takes the write, the output flop copies it one edge later
    chk_rise_copy: assert property (
        wr_third_s |-> ##2 rise_time_mode_out == $past(pwdata_in[1:0], 2))
        else $error("rise mode not updated");
    chk_slot_hold: assert property (
        (time_slot_out != last_q && time_slot_out != 4'h0) |->
            hold_q >= 12'd511) else $error("slot shorter than its time");
endmodule

bind vfd_scan vfd_scan_checker #(
    .NUM_PINS(NUM_PINS),
    .NUM_SLOTS(NUM_SLOTS)
) chk_u (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .hv_pin_in(hv_pin_in),
    .driver_outputs_out(driver_outputs_out),
    .rise_time_mode_out(rise_time_mode_out),
    .time_slot_out(time_slot_out)
);

// ---- test/vfd_tube_model.sv ----
// vfd_tube_model: tube and pull-down network on the high-voltage pins.
// assumes every pin is pulled down; an outside source may lift it.
`timescale 1ns/100ps
module vfd_tube_model (
    input wire logic [36:0] drive_in,
    input wire logic [36:0] ext_level_in,
    output logic [36:0] pin_out
);
    // a released pin falls to the pull-down level unless ext_level_in lifts it, never holds old data
    assign pin_out = drive_in | ext_level_in;
endmodule

// ---- test/vfd_scan_bench.sv ----
// vfd_scan_bench: register, scan and blanking tests for vfd_scan.
// assumes the tube model on the pins and the bound checker.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    fail_count++; $display("wrong value %s expected %h seen %h", nm, exp, \
    got); end end
module vfd_scan_bench;
    logic clock_in, rst_in, psel, penable, pwrite, pready, pslverr, e;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [36:0] hv_pin, drv, ext_level;
    logic [1:0] rise;
    logic [3:0] slot;
    int fail_count, n_checks;
    vfd_scan dut_u (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .hv_pin_in(hv_pin),
        .driver_outputs_out(drv), .rise_time_mode_out(rise),
        .time_slot_out(slot));
    vfd_tube_model tube_u (.drive_in(drv), .ext_level_in(ext_level),
        .pin_out(hv_pin));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] ba(input logic [11:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
    // group 0 holds the digit grids, one per slot
    function automatic logic [7:0] pat(input int s, input int g);
        if (g == 0) begin
            return 8'(1 << s);
        end
        return 8'h5a ^ 8'(8'h11 * g) ^ ((s == 1) ? 8'hff : 8'h00);
    endfunction
    function automatic logic [36:0] row(input int s);
        logic [39:0] w;
        for (int g = 0; g < 5; g++) begin
            w[8*g+:8] = pat(s, g);
        end
        return w[36:0];
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clock_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        // ready, read data and error are taken at the completing edge
        for (n = 0; n < 16; n++) begin
            @(posedge clock_in);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            fail_count++;
            report_and_stop();
        end
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] m,
        input logic [31:0] x, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, x, r & m)
    endtask
    // kind 0 waits for a slot number, kind 1 for a driver pattern
    task automatic wait_for(input int kind, input logic [36:0] v);
        int n;
        for (n = 0; n < 1200; n++) begin
            @(negedge clock_in);
            if (kind == 0 && slot === v[3:0]) break;
            if (kind == 1 && drv === v) break;
        end
        if (n == 1200) begin
            fail_count++;
            report_and_stop();
        end else begin
            repeat (4) @(negedge clock_in);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    initial begin
        rst_in = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        ext_level = 37'h00000000f0;
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        rd_chk(ba(vfd_pkg::VFD_IDX_CTRL_FIRST), 32'hff, 32'h01, "first");
        rd_chk(ba(vfd_pkg::VFD_IDX_CTRL_SECOND), 32'hff, 32'hff, "second");
        rd_chk(ba(vfd_pkg::VFD_IDX_STATUS), 32'h03, 32'h01, "status");
        rd_chk(ba(vfd_pkg::VFD_IDX_LATCH_LO), '1, 32'h0, "latch lo");
        rd_chk(ba(vfd_pkg::VFD_IDX_LATCH_HI), 32'h1f, 32'h0, "latch hi");
        rd_chk(ba(vfd_pkg::VFD_IDX_PIN_LO), '1, 32'hf0, "pin lo");
        apb(1'b0, 16'h0100, 32'h0);
        `CHK("unmapped", 1'b1, e)
        apb(1'b1, ba(vfd_pkg::VFD_IDX_CTRL_THIRD) | 16'h1, 32'h3);
        `CHK("misaligned", 1'b1, e)
        rd_chk(ba(vfd_pkg::VFD_IDX_CTRL_THIRD), 32'hff, 32'h0, "third");
        apb(1'b1, ba(vfd_pkg::VFD_IDX_CTRL_THIRD), 32'h3);
        repeat (2) @(negedge clock_in);
        `CHK("rise mode", 2'h3, rise)
        for (int s = 0; s < 2; s++) begin
            for (int g = 0; g < 5; g++) begin
                apb(1'b1, ba(vfd_pkg::VFD_IDX_BUF_FIRST + 12'(16 * g + s)),
                    {24'h0, pat(s, g)});
            end
        end
        rd_chk(ba(vfd_pkg::VFD_IDX_BUF_FIRST + 12'h041), 32'hff,
            {24'h0, pat(1, 4)}, "buffer");
        apb(1'b1, ba(vfd_pkg::VFD_IDX_CTRL_SECOND), 32'hf1);
        apb(1'b1, ba(vfd_pkg::VFD_IDX_CTRL_FIRST), 32'hf8);
        rd_chk(ba(vfd_pkg::VFD_IDX_STATUS), 32'h03, 32'h02, "running");
        repeat (4) @(negedge clock_in);
        `CHK("slot 0", row(0), drv)
        wait_for(0, 37'h1);
        `CHK("slot 1", row(1), drv)
        wait_for(0, 37'h0);
        `CHK("wrapped", row(0), drv)
        apb(1'b1, ba(vfd_pkg::VFD_IDX_CTRL_FIRST), 32'hf9);
        rd_chk(ba(vfd_pkg::VFD_IDX_STATUS), 32'h03, 32'h02, "busy");
        `CHK("slot kept", row(0), drv)
        wait_for(1, 37'h0);
        rd_chk(ba(vfd_pkg::VFD_IDX_STATUS), 32'h01, 32'h01, "done");
        // slot 1 now selects two grids at once
        apb(1'b1, ba(vfd_pkg::VFD_IDX_BUF_FIRST + 12'h001),
            32'h03);
        apb(1'b1, ba(vfd_pkg::VFD_IDX_CTRL_FIRST), 32'hf8);
        apb(1'b1, ba(vfd_pkg::VFD_IDX_CTRL_SECOND), 32'h01);
        wait_for(0, 37'h1);
        `CHK("two grids", row(1) | 37'h1, drv)
        repeat (100) @(negedge clock_in);
        `CHK("dimmed", 37'h0, drv)
        // pin 8 turns into a plain output, so its buffer bit is cleared
        apb(1'b1, ba(vfd_pkg::VFD_IDX_BUF_FIRST + 12'h010),
            {24'h0, pat(0, 1) & 8'hfe});
        apb(1'b1, ba(vfd_pkg::VFD_IDX_LATCH_LO), 32'h100);
        repeat (3) @(negedge clock_in);
        `CHK("latch pin", 37'h100, drv)
        report_and_stop();
    end
endmodule
